// ---- include/rcw_pkg.sv ----
/*
  Constants for the runaway code watchdog: register map, configuration
  field positions, reset values and timing counts.
  Assumes one 100 MHz system clock and an 8-bit register port.
*/
// Operation
// - A 6-bit counter runs on the output of a 12-bit prescaler.
// - Uncleared counter overflows and raises reset after 8176 or 262128 cycles.
// - Rate select set gives 8176 cycles, clear gives 262128; reset clears it.
// - Any write to the clear location clears counter and prescaler stages 4-12; while disabled the counter keeps its value.
// - Reads of the clear location return the reset vector low byte.
// - Watchdog reset holds reset pin low 32 cycles and sets cause flag.
// - Power-on reset clears the prescaler 4096 cycles after power-up.
// - Any internal reset clears prescaler and counter.
// - A reset vector fetch clears the prescaler.
// - Disable bit 1 turns the watchdog off; 0 lets it reset.
// - Monitor mode with test voltage on interrupt or reset pin disables it.
// - Break with test voltage on reset pin disables the watchdog.
// - The watchdog raises no processor interrupt, only a reset.
// - In wait mode the watchdog keeps counting.
// - Stop instruction gates the reference clock off and clears the prescaler.
// - Stop enable bit 1 runs stop normally; 0 makes it an illegal opcode.
// - The time base is the oscillator reference clock.
// - Configuration bits reset to zero, take one write per reset, always readable.
package rcw_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] RCW_CLEAR_PORT_ADDR = 16'hFFFF;
  localparam logic [15:0] RCW_VECTOR_HI_ADDR  = 16'hFFFE;
  localparam logic [15:0] RCW_OPTION_ADDR     = 16'h001F;
  localparam logic [15:0] RCW_CAUSE_ADDR      = 16'h0001;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RCW_OPT_DISABLE_BIT  = 0;
  localparam int RCW_OPT_STOP_EN_BIT  = 1;
  localparam int RCW_OPT_RATE_BIT     = 7;
  localparam int RCW_CAUSE_WDOG_BIT   = 4;
  localparam int RCW_CAUSE_ILLOP_BIT  = 3;
  localparam int RCW_CAUSE_POR_BIT    = 7;

  localparam logic [7:0] RCW_OPTION_RESET = 8'h00;
  localparam logic [7:0] RCW_CAUSE_RESET  = 8'h80;

  // ****************************************
  // Timing
  // ****************************************
  localparam int RCW_PRESCALER_BITS    = 12;
  localparam int RCW_COUNTER_BITS      = 6;
  localparam int RCW_PRESC_CLEAR_LOW   = 4;
  localparam int RCW_TIMEOUT_SHORT     = 8176;
  localparam int RCW_TIMEOUT_LONG      = 262128;
  localparam int RCW_RESET_PULSE       = 32;
  localparam int RCW_POR_DELAY         = 4096;
  localparam int RCW_PULSE_BITS        = 6;
  // Short period taps prescaler stage 7, long period taps stage 12
  localparam int RCW_SHORT_TAP         = 6;
  localparam int RCW_LONG_TAP          = 11;

  typedef enum logic [1:0]
  {
    RCW_ST_POR   = 2'b00,
    RCW_ST_RUN   = 2'b01,
    RCW_ST_PULSE = 2'b10
  } rcw_state_type;

endpackage : rcw_pkg

// ---- src/rcw_prescaler.sv ----
/*
  Prescaler of the runaway code watchdog: a 12-bit divider on the
  reference clock enable with full clear and partial clear of stages 4-12.
  Assumes clear requests are synchronous to i_mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module rcw_prescaler
  import rcw_pkg::*;
#(
  parameter int WIDTH = RCW_PRESCALER_BITS
)
(
  input  wire logic             i_mclk,
  input  wire logic             i_reset_n,
  input  wire logic             i_tick,
  input  wire logic             i_clear_all,
  input  wire logic             i_clear_upper,
  output logic [WIDTH-1:0]      o_count,
  output logic [WIDTH-1:0]      o_carry_pulse
);

  typedef struct packed
  {
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] carry;
  } rcw_presc_state_type;

  rcw_presc_state_type state_reg;
  rcw_presc_state_type state_next;

  // ****************************************
  // Divider
  // ****************************************
  always_comb
  begin
    state_next       = state_reg;
    state_next.carry = '0;
    if (i_tick)
    begin
      state_next.count = state_reg.count + 1'b1;
      // A stage carries when it and all below are ones; a chain keeps ranges constant
      state_next.carry[0] = state_reg.count[0];
      for (int i = 1; i < WIDTH; i++)
      begin
        state_next.carry[i] = state_next.carry[i-1] && state_reg.count[i];
      end
    end
    if (i_clear_all)
    begin
      state_next.count = '0;
      state_next.carry = '0;
    end
    else if (i_clear_upper)
    begin
      // Stages 4-12 are bits 3..11; the three low stages keep running
      state_next.count[WIDTH-1:RCW_PRESC_CLEAR_LOW-1] = '0;
      state_next.carry = '0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_count       = state_reg.count;
  assign o_carry_pulse = state_reg.carry;

endmodule // rcw_prescaler
`default_nettype wire

// ---- src/rcw_watchdog.sv ----
/*
  Runaway code watchdog: prescaler, 6-bit timeout counter, write-once
  option latch, reset cause flags and the reset pin pulse.
  Assumes i_ref_tick is a one-cycle enable at the oscillator reference
  rate, and that all inputs are synchronous to i_mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module rcw_watchdog
  import rcw_pkg::*;
#(
  parameter int POR_DELAY = RCW_POR_DELAY
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ref_tick,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_reset_vector,
  input  wire logic        i_internal_reset,
  input  wire logic        i_vector_fetch,
  input  wire logic        i_stop_exec,
  input  wire logic        i_stop_mode,
  input  wire logic        i_monitor_mode,
  input  wire logic        i_break_active,
  input  wire logic        i_irq_test_high_voltage,
  input  wire logic        i_rst_test_high_voltage,
  output logic [7:0]       o_rdata,
  output logic             o_reset_pin_n,
  output logic             o_reset_pin_oe,
  output logic             o_watchdog_reset,
  output logic             o_stop_allowed,
  output logic             o_illegal_stop,
  output logic             o_watchdog_irq
);

  localparam int PB = RCW_PRESCALER_BITS;
  localparam int CB = RCW_COUNTER_BITS;
  localparam int POR_BITS = 16;
  // Overflow lands on the exact period: last counter value plus a prescaler phase
  localparam logic [PB-1:0] SHORT_MASK = PB'((1 << (RCW_SHORT_TAP + 1)) - 1);
  localparam logic [PB-1:0] LONG_MASK  = PB'((1 << (RCW_LONG_TAP + 1)) - 1);
  localparam logic [PB-1:0] SHORT_LAST =
    PB'(RCW_TIMEOUT_SHORT - 1 - (((1 << CB) - 1) << (RCW_SHORT_TAP + 1)));
  localparam logic [PB-1:0] LONG_LAST  =
    PB'(RCW_TIMEOUT_LONG - 1 - (((1 << CB) - 1) << (RCW_LONG_TAP + 1)));

  typedef struct packed
  {
    rcw_state_type         state;
    logic [POR_BITS-1:0]   por_count;
    logic [CB-1:0]         counter;
    logic [RCW_PULSE_BITS-1:0] pulse_count;
    logic [7:0]            option;
    logic                  option_locked;
    logic [7:0]            cause;
    logic [7:0]            rdata;
    logic                  reset_pin_n;
    logic                  reset_pin_oe;
    logic                  wdog_reset;
    logic                  stop_allowed;
    logic                  illegal_stop;
  } rcw_core_state_type;

  rcw_core_state_type state_reg;
  rcw_core_state_type state_next;

  logic [PB-1:0] presc_count;
  logic [PB-1:0] presc_carry;
  logic          presc_clear_all;
  logic          presc_clear_upper;
  logic          clear_write;
  logic          active;
  logic          tap;
  logic          at_last;
  logic          ref_tick_gated;
  logic          disabled_by_test;

  // ****************************************
  // Clear and enable terms
  // ****************************************
  assign clear_write = i_wr && (i_addr == RCW_CLEAR_PORT_ADDR);
  // Stop mode removes the reference clock from all but the reset pin pulse timer
  assign ref_tick_gated = i_ref_tick && !i_stop_mode;
  assign disabled_by_test =
    (i_monitor_mode && (i_irq_test_high_voltage || i_rst_test_high_voltage))
    || (i_break_active && i_rst_test_high_voltage);
  // Option bits are used live, so a late write acts on the next check
  assign active = (state_reg.state == RCW_ST_RUN)
                  && !state_reg.option[RCW_OPT_DISABLE_BIT]
                  && !disabled_by_test;
  assign presc_clear_all = i_internal_reset
                           || i_vector_fetch
                           || (i_stop_exec && state_reg.stop_allowed)
                           || (state_reg.state == RCW_ST_POR)
                           || (state_reg.state == RCW_ST_PULSE);
  assign presc_clear_upper = clear_write;
  // Counter steps on the selected prescaler carry; 63 steps plus a prescaler phase make the period
  assign tap = state_reg.option[RCW_OPT_RATE_BIT] ? presc_carry[RCW_SHORT_TAP]
                                                  : presc_carry[RCW_LONG_TAP];
  assign at_last = state_reg.option[RCW_OPT_RATE_BIT]
                   ? ((presc_count & SHORT_MASK) == SHORT_LAST)
                   : ((presc_count & LONG_MASK) == LONG_LAST);

  rcw_prescaler #(
    .WIDTH (PB)
  ) u_prescaler (
    .i_mclk        (i_mclk),
    .i_reset_n     (i_reset_n),
    .i_tick        (ref_tick_gated),
    .i_clear_all   (presc_clear_all),
    .i_clear_upper (presc_clear_upper),
    .o_count       (presc_count),
    .o_carry_pulse (presc_carry)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    state_next              = state_reg;
    state_next.wdog_reset   = 1'b0;
    state_next.illegal_stop = 1'b0;
    state_next.rdata        = 8'h00;

    case (state_reg.state)
      RCW_ST_POR:
      begin
        // Prescaler is held clear until the power-up delay runs out
        if (ref_tick_gated)
        begin
          if (state_reg.por_count == POR_BITS'(POR_DELAY - 1))
          begin
            state_next.state = RCW_ST_RUN;
          end
          else
          begin
            state_next.por_count = state_reg.por_count + 1'b1;
          end
        end
      end
      RCW_ST_RUN:
      begin
        if (i_internal_reset || !active)
        begin
          if (i_internal_reset)
          begin
            state_next.counter = '0;
          end
        end
        else if (clear_write)
        begin
          state_next.counter = '0;
        end
        else
        begin
          // Carry is already a one-cycle pulse, so sparse ticks are not missed
          if (tap)
          begin
            state_next.counter = state_reg.counter + 1'b1;
          end
          if (ref_tick_gated && (state_reg.counter == '1) && at_last)
          begin
            // Overflow: only a reset, no interrupt request
            state_next.counter      = '0;
            state_next.state        = RCW_ST_PULSE;
            state_next.pulse_count  = '0;
            state_next.reset_pin_n  = 1'b0;
            state_next.reset_pin_oe = 1'b1;
            state_next.wdog_reset   = 1'b1;
            state_next.cause        = 8'h00;
            state_next.cause[RCW_CAUSE_WDOG_BIT] = 1'b1;
          end
        end
      end
      RCW_ST_PULSE:
      begin
        if (i_ref_tick)
        begin
          if (state_reg.pulse_count == RCW_PULSE_BITS'(RCW_RESET_PULSE - 1))
          begin
            // Watchdog reset clears option latch for a fresh write
            state_next.state         = RCW_ST_RUN;
            state_next.reset_pin_n   = 1'b1;
            state_next.reset_pin_oe  = 1'b0;
            state_next.option        = RCW_OPTION_RESET;
            state_next.option_locked = 1'b0;
            state_next.stop_allowed  = 1'b0;
          end
          else
          begin
            state_next.pulse_count = state_reg.pulse_count + 1'b1;
          end
        end
      end
      default:
      begin
        state_next.state = RCW_ST_POR;
      end
    endcase

    // Other internal resets also reopen the option latch
    if (i_internal_reset)
    begin
      state_next.option        = RCW_OPTION_RESET;
      state_next.option_locked = 1'b0;
      state_next.stop_allowed  = 1'b0;
    end
    else if (i_wr && (i_addr == RCW_OPTION_ADDR) && !state_reg.option_locked)
    begin
      state_next.option        = i_wdata;
      state_next.option_locked = 1'b1;
      state_next.stop_allowed  = i_wdata[RCW_OPT_STOP_EN_BIT];
    end

    if (i_stop_exec && !state_reg.stop_allowed)
    begin
      state_next.illegal_stop = 1'b1;
    end

    if (i_rd)
    begin
      case (i_addr)
        RCW_CLEAR_PORT_ADDR: state_next.rdata = i_reset_vector[7:0];
        RCW_VECTOR_HI_ADDR:  state_next.rdata = i_reset_vector[15:8];
        RCW_OPTION_ADDR:     state_next.rdata = state_reg.option;
        RCW_CAUSE_ADDR:      state_next.rdata = state_reg.cause;
        default:             state_next.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg              <= '0;
      state_reg.state        <= RCW_ST_POR;
      state_reg.option       <= RCW_OPTION_RESET;
      state_reg.cause        <= RCW_CAUSE_RESET;
      state_reg.reset_pin_n  <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_rdata          = state_reg.rdata;
  assign o_reset_pin_n    = state_reg.reset_pin_n;
  assign o_reset_pin_oe   = state_reg.reset_pin_oe;
  assign o_watchdog_reset = state_reg.wdog_reset;
  assign o_stop_allowed   = state_reg.stop_allowed;
  assign o_illegal_stop   = state_reg.illegal_stop;
  // Never an interrupt source
  assign o_watchdog_irq   = 1'b0;

endmodule // rcw_watchdog
`default_nettype wire

// ---- sim/rcw_assertions.sv ----
/*
  Port checker for the runaway code watchdog, bound into rcw_watchdog.
  Assumes one clock, i_mclk, and one reference tick per clock.
*/
`timescale 1ns/1ns
`default_nettype none
module rcw_assertions
  import rcw_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic [15:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] i_reset_vector,
  input wire logic        i_internal_reset,
  input wire logic        i_stop_exec,
  input wire logic        i_monitor_mode,
  input wire logic        i_break_active,
  input wire logic        i_irq_test_high_voltage,
  input wire logic        i_rst_test_high_voltage,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_reset_pin_n,
  input wire logic        o_reset_pin_oe,
  input wire logic        o_watchdog_reset,
  input wire logic        o_stop_allowed,
  input wire logic        o_illegal_stop,
  input wire logic        o_watchdog_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // *****
  // Pin low length, counted in clocks
  // *****
  logic [7:0] low_cnt;
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n) low_cnt <= 8'h00;
    else if (o_reset_pin_n) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  logic mon_off;
  logic brk_off;
  assign mon_off = i_monitor_mode && (i_irq_test_high_voltage || i_rst_test_high_voltage);
  assign brk_off = i_break_active && i_rst_test_high_voltage;
  // *****
  // Properties
  // *****
  a_irq_never: assert property (o_watchdog_irq == 1'b0)
    else $error("watchdog irq raised");
  a_pin_driven: assert property (!o_reset_pin_n |-> o_reset_pin_oe)
    else $error("reset pin low without enable");
  a_pulse_width: assert property ($rose(o_reset_pin_n) |-> low_cnt >= 8'h20)
    else $error("reset pulse too short");
  a_pulse_start: assert property ($rose(o_watchdog_reset) |-> ##[0:2] !o_reset_pin_n)
    else $error("overflow without pin pulse");
  a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_vector_low: assert property ($past(i_rd) && $past(i_addr) == RCW_CLEAR_PORT_ADDR
    |-> o_rdata == $past(i_reset_vector[7:0]))
    else $error("clear port read not vector");
  a_stop_decode: assert property (i_stop_exec |=> o_illegal_stop == !$past(o_stop_allowed))
    else $error("stop decode wrong");
  a_illegal_cause: assert property (o_illegal_stop |-> $past(i_stop_exec))
    else $error("illegal stop without stop");
  a_clear_defers: assert property (i_wr && i_addr == RCW_CLEAR_PORT_ADDR
    |=> !o_watchdog_reset [*8])
    else $error("overflow right after clear");
  a_int_reset_quiet: assert property (i_internal_reset |=> !o_watchdog_reset)
    else $error("overflow after internal reset");
  a_monitor_off: assert property (mon_off ##1 mon_off |-> !o_watchdog_reset)
    else $error("overflow in monitor test");
  a_break_off: assert property (brk_off ##1 brk_off |-> !o_watchdog_reset)
    else $error("overflow in break test");
  c_overflow: cover property (o_watchdog_reset);
  c_illegal: cover property (o_illegal_stop);
  c_pulse: cover property ($rose(o_reset_pin_n));
endmodule // rcw_assertions
bind rcw_watchdog rcw_assertions rcw_assertions_inst (.*);
`default_nettype wire

// ---- sim/rcw_watchdog_tb.sv ----
/*
  Self-checking bench for rcw_watchdog: register port, timeout, pulse,
  stop decode and the disable conditions.
  Assumes POR_DELAY of 8 and one reference tick per clock.
*/
`timescale 1ns/1ns
`default_nettype none
module rcw_watchdog_tb
  import rcw_pkg::*;
;
  logic i_mclk = 0, i_reset_n = 0, i_ref_tick = 1, i_wr = 0, i_rd = 0;
  logic i_internal_reset = 0, i_vector_fetch = 0, i_stop_exec = 0, i_stop_mode = 0;
  logic i_monitor_mode = 0, i_break_active = 0;
  logic i_irq_test_high_voltage = 0, i_rst_test_high_voltage = 0;
  logic [15:0] i_addr = 16'h0000, i_reset_vector = 16'h0000;
  logic [7:0] i_wdata = 8'h00, o_rdata, d;
  logic o_reset_pin_n, o_reset_pin_oe, o_watchdog_reset, o_stop_allowed;
  logic o_illegal_stop, o_watchdog_irq, h;
  int n_errors = 0, n_compared = 0, cyc = 0, n;
  rcw_watchdog #(.POR_DELAY(8)) rcw_watchdog_inst (.*);
  always #5 i_mclk = ~i_mclk;
  // *****
  // Shared tasks
  // *****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a; i_wdata <= v; i_wr <= 1;
    @(posedge i_mclk);
    i_wr <= 0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge i_mclk);
    i_addr <= a; i_rd <= 1;
    @(posedge i_mclk);
    i_rd <= 0;
    #1 d = o_rdata;
  endtask
  // Waits k clocks and notes any overflow; a quiet wait must stay clean
  task automatic idle(input int k);
    h = 0;
    repeat (k)
    begin
      @(posedge i_mclk);
      #1 h = h | o_watchdog_reset;
    end
  endtask
  task automatic stop_pulse();
    @(posedge i_mclk) i_stop_exec <= 1;
    @(posedge i_mclk) i_stop_exec <= 0;
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Ceiling set well above the roughly 65000 clocks the tests need
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  // *****
  // Tests
  // *****
  initial
  begin
    n = $urandom(32'hB890);
    i_reset_vector = 16'($urandom);
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1;
    rd(RCW_OPTION_ADDR); check(d, RCW_OPTION_RESET);
    rd(RCW_CAUSE_ADDR); check(d, RCW_CAUSE_RESET);
    rd(RCW_CLEAR_PORT_ADDR); check(d, i_reset_vector[7:0]);
    rd(RCW_VECTOR_HI_ADDR); check(d, i_reset_vector[15:8]);
    rd(16'h1234); check(d, 16'h0000);
    check(o_watchdog_irq, 1'b0);
    wr(RCW_OPTION_ADDR, 8'h82);
    wr(RCW_OPTION_ADDR, 8'h01);
    rd(RCW_OPTION_ADDR); check(d, 16'h0082);
    check(o_stop_allowed, 1'b1);
    $display("registers done");
    wr(RCW_CLEAR_PORT_ADDR, 8'($urandom));
    stop_pulse(); check(o_illegal_stop, 1'b0);
    i_stop_mode <= 1;
    idle(9000); check(h, 1'b0);
    i_stop_mode <= 0;
    repeat (3)
    begin
      idle(4000); check(h, 1'b0);
      wr(RCW_CLEAR_PORT_ADDR, 8'($urandom));
    end
    for (n = 0; n < 9000 && o_watchdog_reset !== 1'b1; n++) @(posedge i_mclk) #1;
    check(n >= 8000 && n <= 8200, 1'b1);
    for (n = 0; n < 4 && o_reset_pin_n !== 1'b0; n++) @(posedge i_mclk) #1;
    for (n = 0; n < 100 && o_reset_pin_n === 1'b0; n++) @(posedge i_mclk) #1;
    check(n, RCW_RESET_PULSE);
    rd(RCW_CAUSE_ADDR); check(d, 16'h0010);
    rd(RCW_OPTION_ADDR); check(d, RCW_OPTION_RESET);
    $display("timeout done");
    wr(RCW_OPTION_ADDR, 8'h00);
    idle(9000); check(h, 1'b0);
    stop_pulse(); check(o_illegal_stop, 1'b1);
    @(posedge i_mclk) i_internal_reset <= 1;
    @(posedge i_mclk) i_internal_reset <= 0;
    rd(RCW_OPTION_ADDR); check(d, RCW_OPTION_RESET);
    wr(RCW_OPTION_ADDR, 8'h80);
    wr(RCW_CLEAR_PORT_ADDR, 8'($urandom));
    i_monitor_mode <= 1; i_irq_test_high_voltage <= 1;
    idle(9000); check(h, 1'b0);
    i_monitor_mode <= 0; i_irq_test_high_voltage <= 0;
    wr(RCW_CLEAR_PORT_ADDR, 8'($urandom));
    i_break_active <= 1; i_rst_test_high_voltage <= 1;
    idle(9000); check(h, 1'b0);
    i_break_active <= 0; i_rst_test_high_voltage <= 0;
    $display("modes done");
    @(posedge i_mclk) i_internal_reset <= 1;
    @(posedge i_mclk) i_internal_reset <= 0;
    wr(RCW_OPTION_ADDR, 8'h81);
    idle(9000); check(h, 1'b0);
    $display("disable done");
    tally_and_finish();
  end
endmodule // rcw_watchdog_tb
`default_nettype wire
